// ==== rtl/cpu_state.sv ====
// cpu architectural state: condition flags, register file, pointers and stack pointer
// Operation
// [RL1] flag register answers at data address 0x5F and io address 0x3F
// [RL2] reset clears every flag bit, interrupt enable included
// [RL3] bit 7 is global interrupt enable; clear blocks every interrupt
// [RL4] interrupt acceptance clears enable; interrupt return sets it again
// [RL5] enable and disable instructions set and clear the enable bit
// [RL6] bit 6 copy store: bit-store loads it, bit-load writes it out
// [RL7] bit 5 records half carry out of the low nibble
// [RL8] bit 4 always equals negative xor overflow
// [RL9] bit 3 records two's complement overflow of latest arithmetic result
// [RL10] bit 2 set when result msb is one
// [RL11] bit 1 set when result is zero
// [RL12] bit 0 captures carry of the operation
// [RL13] software saves and restores flags around interrupt handlers
// [RL14] file offers 8/8, two-8/8, two-8/16 and 16/16 port schemes
// [RL15] registers also reachable as data addresses 0x00 to 0x1F
// [RL16] registers 26..31 form three 16-bit pointers, low byte lower
// [RL17] pointers support displacement, post increment and pre decrement with write back
// [RL18] stack grows downward; pointer marks top of stack
// [RL19] byte push decrements by 1, byte pop increments by 1
// [RL20] calls and interrupt entry subtract 2; returns add 2
// [RL21] software sets the stack pointer before calls or interrupts
// [RL22] stack pointer 16 bits at 0x5D/0x5E, reset 0x10FF
// [RL23] pointer increment and decrement carry across both bytes
`timescale 1ns/10ps
`default_nettype none

module cpu_state (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // register file operand and result ports
  input  wire logic [4:0]            rd_a_addr_i,
  input  wire logic [4:0]            rd_b_addr_i,
  output logic [7:0]                 rd_a_data_o,
  output logic [7:0]                 rd_b_data_o,
  output logic [15:0]                rd_pair_data_o,
  input  wire logic                  res_wr_i,
  input  wire logic                  res_wide_i,
  input  wire logic [4:0]            res_addr_i,
  input  wire logic [15:0]           res_data_i,
  // alu flag update: one enable each for h, v, n, z and c; sign is derived
  input  wire logic                  alu_upd_i,
  input  wire logic [5:0]            alu_flag_mask_i,
  input  wire logic [7:0]            alu_result_i,
  input  wire logic                  alu_carry_i,
  input  wire logic                  alu_half_i,
  input  wire logic                  alu_ovf_i,
  // interrupt enable control
  input  wire cpu_state_pkg::gie_op_t gie_op_i,
  input  wire logic                  irq_accept_i,
  input  wire logic                  irq_return_instr_i,
  input  wire logic                  irq_request_i,
  output logic                       irq_take_o,
  // bit copy
  input  wire logic                  bit_store_instr_i,
  input  wire logic                  bit_load_instr_i,
  input  wire logic [4:0]            bit_reg_i,
  input  wire logic [2:0]            bit_sel_i,
  // pointer addressing
  input  wire cpu_state_pkg::ptr_op_t ptr_op_i,
  input  wire logic [4:0]            ptr_sel_i,
  input  wire logic [5:0]            ptr_disp_i,
  output logic [15:0]                ptr_addr_o,
  // stack
  input  wire cpu_state_pkg::sp_op_t sp_op_i,
  output logic [15:0]                stack_addr_o,
  output logic [15:0]                stack_pointer_o,
  // data-space access (loads, stores, io)
  input  wire logic                  ds_rd_i,
  input  wire logic                  ds_wr_i,
  input  wire logic                  ds_io_i,
  input  wire logic [15:0]           ds_addr_i,
  input  wire logic [7:0]            ds_wdata_i,
  output logic                       ds_hit_o,
  output logic [7:0]                 ds_rdata_o,
  output logic [7:0]                 cpu_condition_flags_o
);

  // ****************************************
  // address decode
  // ****************************************
  logic [15:0] eff_addr;
  logic        hit_flags, hit_spl, hit_sph, hit_gpr, ds_gpr_rd;

  always_comb begin
    eff_addr = ds_io_i ? (16'(ds_addr_i[5:0]) + cpu_state_pkg::IO_TO_DATA_OFS) : ds_addr_i; // [RL1]
  end
  assign hit_flags = eff_addr == cpu_state_pkg::FLAGS_DATA_ADDR; // [RL1]
  assign hit_spl   = eff_addr == cpu_state_pkg::SP_LOW_ADDR;     // [RL22]
  assign hit_sph   = eff_addr == cpu_state_pkg::SP_HIGH_ADDR;    // [RL22]
  assign hit_gpr   = !ds_io_i && eff_addr <= cpu_state_pkg::GPR_LAST_ADDR; // [RL15]
  assign ds_hit_o  = (ds_rd_i || ds_wr_i) && (hit_flags || hit_spl || hit_sph || hit_gpr);
  // port b is borrowed only while a load is in flight, so a stale address never steals it
  assign ds_gpr_rd = ds_rd_i && hit_gpr; // [RL15]

  // ****************************************
  // register file and its write arbitration
  // ****************************************
  logic [4:0]  rf_rd_a, rf_wr_addr;
  logic [7:0]  rf_a, rf_b;
  logic [15:0] rf_pair, rf_wr_data;
  logic        rf_wr, rf_wide;
  logic [15:0] ptr_cur, ptr_next;
  logic [7:0]  bld_byte;

  // pointer and bit-load work share read port a, so the decoder never issues them
  // together with an unrelated port-a operand; that costs a port, not a cycle
  always_comb begin
    rf_rd_a = rd_a_addr_i;
    if (ptr_op_i != cpu_state_pkg::PTR_NONE || ptr_disp_i != 6'h00) begin
      rf_rd_a = ptr_sel_i;
    end else if (bit_load_instr_i || bit_store_instr_i) begin
      rf_rd_a = bit_reg_i;
    end
  end

  assign ptr_cur = rf_pair; // [RL16]

  always_comb begin
    bld_byte = rf_a;
    bld_byte[bit_sel_i] = cpu_condition_flags_o[cpu_state_pkg::FLAG_T]; // [RL6]
    case (ptr_op_i)
      cpu_state_pkg::PTR_INC: ptr_next = ptr_cur + 16'h0001; // [RL17] [RL23]
      cpu_state_pkg::PTR_DEC: ptr_next = ptr_cur - 16'h0001; // [RL17] [RL23]
      default:                ptr_next = ptr_cur;
    endcase
    // pre-decrement addresses with the new value, post-increment with the old
    if (ptr_op_i == cpu_state_pkg::PTR_DEC) begin
      ptr_addr_o = ptr_next;
    end else begin
      ptr_addr_o = ptr_cur + {10'h000, ptr_disp_i}; // [RL17]
    end
    // result write beats pointer write back beats data-space write
    rf_wr      = 1'b0;
    rf_wide    = 1'b0;
    rf_wr_addr = res_addr_i;
    rf_wr_data = res_data_i;
    if (res_wr_i) begin
      rf_wr   = 1'b1;
      rf_wide = res_wide_i; // [RL14]
    end else if (bit_load_instr_i) begin
      rf_wr      = 1'b1;
      rf_wr_addr = bit_reg_i;
      rf_wr_data = {8'h00, bld_byte}; // [RL6]
    end else if (ptr_op_i != cpu_state_pkg::PTR_NONE) begin
      rf_wr      = 1'b1;
      rf_wide    = 1'b1;
      rf_wr_addr = ptr_sel_i;
      rf_wr_data = ptr_next; // [RL17]
    end else if (ds_wr_i && hit_gpr) begin
      rf_wr      = 1'b1;
      rf_wr_addr = eff_addr[4:0]; // [RL15]
      rf_wr_data = {8'h00, ds_wdata_i};
    end
  end

  gpr_file #(
    .NUM_REGS (32)
  ) gpr_file_inst (
    .clk_i          (clk_i),
    .sys_rst_i      (sys_rst_i),
    .rd_a_addr_i    (rf_rd_a),
    .rd_b_addr_i    (ds_gpr_rd ? eff_addr[4:0] : rd_b_addr_i),
    .rd_a_data_o    (rf_a),
    .rd_b_data_o    (rf_b),
    .rd_pair_data_o (rf_pair),
    .wr_en_i        (rf_wr),
    .wr_wide_i      (rf_wide),
    .wr_addr_i      (rf_wr_addr),
    .wr_data_i      (rf_wr_data)
  ); // [RL14]

  assign rd_a_data_o    = rf_a;
  assign rd_b_data_o    = rf_b;
  assign rd_pair_data_o = rf_pair;

  // ****************************************
  // condition flags
  // ****************************************
  logic [7:0] flags_q, flags_d;
  logic       n_new, v_new;

  assign cpu_condition_flags_o = flags_q;
  // a disabled interrupt is never taken, whatever the peripheral enables say
  assign irq_take_o = irq_request_i && flags_q[cpu_state_pkg::FLAG_I]
                      && gie_op_i != cpu_state_pkg::GIE_CLEAR; // [RL3]

  always_comb begin
    flags_d = flags_q;
    if (ds_wr_i && hit_flags) begin
      flags_d = ds_wdata_i; // [RL1] [RL13]
    end
    if (alu_upd_i) begin
      if (alu_flag_mask_i[cpu_state_pkg::FLAG_C]) flags_d[cpu_state_pkg::FLAG_C] = alu_carry_i; // [RL12]
      if (alu_flag_mask_i[cpu_state_pkg::FLAG_Z]) flags_d[cpu_state_pkg::FLAG_Z] = alu_result_i == 8'h00; // [RL11]
      if (alu_flag_mask_i[cpu_state_pkg::FLAG_N]) flags_d[cpu_state_pkg::FLAG_N] = alu_result_i[7]; // [RL10]
      if (alu_flag_mask_i[cpu_state_pkg::FLAG_V]) flags_d[cpu_state_pkg::FLAG_V] = alu_ovf_i; // [RL9]
      if (alu_flag_mask_i[cpu_state_pkg::FLAG_H]) flags_d[cpu_state_pkg::FLAG_H] = alu_half_i; // [RL7]
    end
    if (bit_store_instr_i) begin
      flags_d[cpu_state_pkg::FLAG_T] = rf_a[bit_sel_i]; // [RL6]
    end
    case (gie_op_i)
      cpu_state_pkg::GIE_SET:   flags_d[cpu_state_pkg::FLAG_I] = 1'b1; // [RL5]
      cpu_state_pkg::GIE_CLEAR: flags_d[cpu_state_pkg::FLAG_I] = 1'b0; // [RL5]
      default: ;
    endcase
    if (irq_return_instr_i) flags_d[cpu_state_pkg::FLAG_I] = 1'b1; // [RL4]
    if (irq_accept_i)       flags_d[cpu_state_pkg::FLAG_I] = 1'b0; // [RL4]
    // sign is derived, so even a direct write keeps it consistent
    n_new = flags_d[cpu_state_pkg::FLAG_N];
    v_new = flags_d[cpu_state_pkg::FLAG_V];
    flags_d[cpu_state_pkg::FLAG_S] = n_new ^ v_new; // [RL8]
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_q <= cpu_state_pkg::FLAGS_RESET; // [RL2]
    end else begin
      flags_q <= flags_d;
    end
  end

  // ****************************************
  // stack pointer
  // ****************************************
  logic [15:0] sp_q, sp_d;

  assign stack_pointer_o = sp_q;
  // a push writes at the current top, then moves down; a pop moves up first
  assign stack_addr_o = (sp_op_i == cpu_state_pkg::SP_POP1 || sp_op_i == cpu_state_pkg::SP_POP2)
                        ? sp_q + 16'h0001 : sp_q; // [RL18]

  always_comb begin
    sp_d = sp_q;
    if (ds_wr_i && hit_spl) sp_d[7:0]  = ds_wdata_i; // [RL22] [RL21]
    if (ds_wr_i && hit_sph) sp_d[15:8] = ds_wdata_i; // [RL22]
    case (sp_op_i)
      cpu_state_pkg::SP_PUSH1: sp_d = sp_q - 16'h0001; // [RL19]
      cpu_state_pkg::SP_POP1:  sp_d = sp_q + 16'h0001; // [RL19]
      cpu_state_pkg::SP_PUSH2: sp_d = sp_q - 16'h0002; // [RL20]
      cpu_state_pkg::SP_POP2:  sp_d = sp_q + 16'h0002; // [RL20]
      default: ;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sp_q <= cpu_state_pkg::SP_RESET; // [RL22]
    end else begin
      sp_q <= sp_d;
    end
  end

  // ****************************************
  // data-space read mux
  // ****************************************
  always_comb begin
    ds_rdata_o = 8'h00;
    if (hit_flags)      ds_rdata_o = flags_q; // [RL1]
    else if (hit_spl)   ds_rdata_o = sp_q[7:0];
    else if (hit_sph)   ds_rdata_o = sp_q[15:8];
    else if (hit_gpr)   ds_rdata_o = rf_b; // [RL15]
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_irq_accepted;
    irq_accept_i;
  endsequence

  a_sign_consistent: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    flags_q[4] == (flags_q[2] ^ flags_q[3])) // [RL8]
    else $error("sign flag differs from n xor v");
  a_gie_cleared_irq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_irq_accepted |=> !flags_q[7]) // [RL4]
    else $error("enable not cleared after interrupt accept");
  a_gie_irq_return_instr_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_return_instr_i && !irq_accept_i |=> flags_q[7]) // [RL4]
    else $error("enable not set by interrupt return");
  a_irq_blocked: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !flags_q[7] |-> !irq_take_o) // [RL3]
    else $error("interrupt taken while disabled");
  a_zero_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    alu_upd_i && alu_flag_mask_i[1] |=> flags_q[1] == ($past(alu_result_i) == 8'h00)) // [RL11]
    else $error("zero flag wrong");
  a_neg_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    alu_upd_i && alu_flag_mask_i[2] |=> flags_q[2] == $past(alu_result_i[7])) // [RL10]
    else $error("negative flag wrong");
  a_sp_push_two: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sp_op_i == cpu_state_pkg::SP_PUSH2 |=> sp_q == $past(sp_q) - 16'h0002) // [RL20]
    else $error("call did not lower stack pointer by two");
  a_sp_pop_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sp_op_i == cpu_state_pkg::SP_POP1 |=> sp_q == $past(sp_q) + 16'h0001) // [RL19]
    else $error("pop did not raise stack pointer by one");
  a_flags_io_alias: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ds_io_i && ds_addr_i[5:0] == cpu_state_pkg::FLAGS_IO_ADDR |-> hit_flags) // [RL1]
    else $error("io alias of flags not decoded");

endmodule : cpu_state

`default_nettype wire

// ==== include/cpu_state_pkg.sv ====
// package: addresses, field positions, reset values and operation codes of the cpu state block
`default_nettype none
package cpu_state_pkg;

  // ****************************************
  // data-space addresses
  // ****************************************
  localparam logic [15:0] FLAGS_DATA_ADDR = 16'h005F;
  localparam logic [15:0] IO_TO_DATA_OFS  = 16'h0020;
  localparam logic [5:0]  FLAGS_IO_ADDR   = 6'h3F;
  localparam logic [15:0] SP_LOW_ADDR     = 16'h005D;
  localparam logic [15:0] SP_HIGH_ADDR    = 16'h005E;
  localparam logic [5:0]  SP_LOW_IO_ADDR  = 6'h3D;
  localparam logic [5:0]  SP_HIGH_IO_ADDR = 6'h3E;
  localparam logic [15:0] GPR_LAST_ADDR   = 16'h001F;

  // ****************************************
  // flag field positions
  // ****************************************
  localparam int FLAG_I = 7;
  localparam int FLAG_T = 6;
  localparam int FLAG_H = 5;
  localparam int FLAG_S = 4;
  localparam int FLAG_V = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;

  // ****************************************
  // reset values and pointer pairs
  // ****************************************
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET    = 16'h10FF;
  localparam logic [4:0]  PTR_X_LOW   = 5'h1A;
  localparam logic [4:0]  PTR_Y_LOW   = 5'h1C;
  localparam logic [4:0]  PTR_Z_LOW   = 5'h1E;

  // ****************************************
  // operation codes
  // ****************************************
  typedef enum logic [2:0] {
    SP_HOLD, SP_PUSH1, SP_POP1, SP_PUSH2, SP_POP2
  } sp_op_t;

  typedef enum logic [1:0] {
    PTR_NONE, PTR_INC, PTR_DEC
  } ptr_op_t;

  typedef enum logic [1:0] {
    GIE_HOLD, GIE_SET, GIE_CLEAR
  } gie_op_t;

endpackage : cpu_state_pkg

`default_nettype wire

// ==== rtl/gpr_file.sv ====
// general purpose register file: two read ports, one write port of 8 or 16 bits
`timescale 1ns/10ps
`default_nettype none

module gpr_file #(
  parameter int NUM_REGS = 32
) (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [4:0] rd_a_addr_i,
  input  wire logic [4:0] rd_b_addr_i,
  output logic [7:0]      rd_a_data_o,
  output logic [7:0]      rd_b_data_o,
  output logic [15:0]     rd_pair_data_o,
  input  wire logic       wr_en_i,
  input  wire logic       wr_wide_i,
  input  wire logic [4:0] wr_addr_i,
  input  wire logic [15:0] wr_data_i
);

  // ****************************************
  // storage
  // ****************************************
  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] regs_d [NUM_REGS];
  logic [4:0] wr_hi_addr;

  assign wr_hi_addr = wr_addr_i | 5'h01;

  // a wide write always lands on an even/odd pair, low byte in the even register
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      always_comb begin
        regs_d[g] = regs_q[g];
        if (wr_en_i && !wr_wide_i && wr_addr_i == 5'(g)) begin
          regs_d[g] = wr_data_i[7:0];
        end else if (wr_en_i && wr_wide_i && {wr_addr_i[4:1], 1'b0} == 5'(g)) begin
          regs_d[g] = wr_data_i[7:0];
        end else if (wr_en_i && wr_wide_i && wr_hi_addr == 5'(g)) begin
          regs_d[g] = wr_data_i[15:8];
        end
      end
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          regs_q[g] <= 8'h00;
        end else begin
          regs_q[g] <= regs_d[g];
        end
      end
    end
  endgenerate

  // reads are combinational so an operation completes in a single cycle
  assign rd_a_data_o    = regs_q[rd_a_addr_i];
  assign rd_b_data_o    = regs_q[rd_b_addr_i];
  assign rd_pair_data_o = {regs_q[rd_a_addr_i | 5'h01], regs_q[{rd_a_addr_i[4:1], 1'b0}]};

endmodule : gpr_file

`default_nettype wire

// ==== bench/alu_add_model.sv ====
// partner alu model: 8-bit adder feeding result and flag inputs of the state block
`timescale 1ns/10ps
`default_nettype none

module alu_add_model (
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  output logic [7:0]      sum_o,
  output logic            carry_o,
  output logic            half_o,
  output logic            ovf_o
);
  // ****************************************
  // adder
  // ****************************************
  logic [8:0] full;
  logic [4:0] low;
  // combinational on purpose: the block samples these on the update edge
  always_comb begin
    full    = {1'b0, a_i} + {1'b0, b_i};
    low     = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
    sum_o   = full[7:0];
    carry_o = full[8];
    half_o  = low[4];
    ovf_o   = (a_i[7] == b_i[7]) && (full[7] != a_i[7]);
  end
endmodule : alu_add_model

`default_nettype wire

// ==== bench/cpu_state_tb.sv ====
// testbench: drives the cpu state block like decoder, alu and interrupt logic
`timescale 1ns/10ps
`default_nettype none

module cpu_state_tb;
  // ****************************************
  // signals
  // ****************************************
  logic                         clk_i, sys_rst_i;
  logic [4:0]                   rd_a_addr_i, rd_b_addr_i, res_addr_i, bit_reg_i, ptr_sel_i;
  logic [7:0]                   rd_a_data_o, rd_b_data_o, alu_result_i, alu_a, alu_b;
  logic [15:0]                  rd_pair_data_o, res_data_i, ptr_addr_o, ds_addr_i;
  logic [15:0]                  stack_addr_o, stack_pointer_o;
  logic                         res_wr_i, res_wide_i, alu_upd_i, alu_carry_i, alu_half_i;
  logic                         alu_ovf_i, irq_accept_i, irq_return_instr_i, irq_request_i;
  logic                         irq_take_o, bit_store_instr_i, bit_load_instr_i;
  logic                         ds_rd_i, ds_wr_i, ds_io_i, ds_hit_o;
  logic [5:0]                   alu_flag_mask_i, ptr_disp_i;
  logic [2:0]                   bit_sel_i;
  logic [7:0]                   ds_wdata_i, ds_rdata_o, cpu_condition_flags_o;
  cpu_state_pkg::gie_op_t       gie_op_i;
  cpu_state_pkg::ptr_op_t       ptr_op_i;
  cpu_state_pkg::sp_op_t        sp_op_i;
  cpu_state_pkg::sp_op_t        ops [4];
  logic [15:0]                  sa_exp [4];
  logic [15:0]                  sp_exp [4];
  int                           failures, checked, cycles;

  cpu_state cpu_state_inst (.clk_i, .sys_rst_i, .rd_a_addr_i, .rd_b_addr_i, .rd_a_data_o,
    .rd_b_data_o, .rd_pair_data_o, .res_wr_i, .res_wide_i, .res_addr_i, .res_data_i,
    .alu_upd_i, .alu_flag_mask_i, .alu_result_i, .alu_carry_i, .alu_half_i, .alu_ovf_i,
    .gie_op_i, .irq_accept_i, .irq_return_instr_i, .irq_request_i, .irq_take_o,
    .bit_store_instr_i, .bit_load_instr_i, .bit_reg_i, .bit_sel_i, .ptr_op_i, .ptr_sel_i,
    .ptr_disp_i, .ptr_addr_o, .sp_op_i, .stack_addr_o, .stack_pointer_o, .ds_rd_i,
    .ds_wr_i, .ds_io_i, .ds_addr_i, .ds_wdata_i, .ds_hit_o, .ds_rdata_o,
    .cpu_condition_flags_o);

  alu_add_model alu_add_model_inst (.a_i(alu_a), .b_i(alu_b), .sum_o(alu_result_i),
    .carry_o(alu_carry_i), .half_o(alu_half_i), .ovf_o(alu_ovf_i));

  always #2 clk_i = ~clk_i;

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick();
    @(negedge clk_i);
  endtask : tick

  task automatic ds_write(input logic io, input logic [15:0] a, input logic [7:0] d);
    tick();
    ds_io_i    = io;
    ds_addr_i  = a;
    ds_wdata_i = d;
    ds_wr_i    = 1'b1;
    tick();
    ds_wr_i    = 1'b0;
  endtask : ds_write

  // reads are combinational: look a moment after the inputs settle
  task automatic ds_chk(input logic io, input logic [15:0] a, input logic hit,
                        input logic [7:0] exp);
    tick();
    ds_io_i   = io;
    ds_addr_i = a;
    ds_rd_i   = 1'b1;
    #1 check({7'h00, ds_hit_o, ds_rdata_o}, {7'h00, hit, exp});
    tick();
    ds_rd_i   = 1'b0;
  endtask : ds_chk

  task automatic res_write(input logic wide, input logic [4:0] a, input logic [15:0] d);
    tick();
    res_wide_i = wide;
    res_addr_i = a;
    res_data_i = d;
    res_wr_i   = 1'b1;
    tick();
    res_wr_i   = 1'b0;
  endtask : res_write

  task automatic alu_op(input logic [7:0] a, input logic [7:0] b, input logic [5:0] m);
    tick();
    alu_a           = a;
    alu_b           = b;
    alu_flag_mask_i = m;
    alu_upd_i       = 1'b1;
    tick();
    alu_upd_i       = 1'b0;
  endtask : alu_op

  task automatic report_and_stop();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // a healthy run needs under a hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      report_and_stop();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {clk_i, res_wr_i, res_wide_i, alu_upd_i, irq_accept_i, irq_return_instr_i} = '0;
    {irq_request_i, bit_store_instr_i, bit_load_instr_i, ds_rd_i, ds_wr_i, ds_io_i} = '0;
    {rd_a_addr_i, rd_b_addr_i, res_addr_i, bit_reg_i, ptr_sel_i, bit_sel_i} = '0;
    {res_data_i, ds_addr_i, ds_wdata_i, alu_a, alu_b, alu_flag_mask_i, ptr_disp_i} = '0;
    {failures, checked, cycles} = '0;
    gie_op_i  = cpu_state_pkg::GIE_HOLD;
    ptr_op_i  = cpu_state_pkg::PTR_NONE;
    sp_op_i   = cpu_state_pkg::SP_HOLD;
    sys_rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    tick();
    sys_rst_i = 1'b0;
    ds_chk(0, 16'h005F, 1, 8'h00);
    ds_chk(0, 16'h005D, 1, 8'hFF);
    ds_chk(1, 16'h003E, 1, 8'h10);
    $display("test reset done");
    ds_write(0, 16'h005F, 8'h08);
    ds_chk(1, 16'h003F, 1, 8'h18);
    ds_write(1, 16'h003F, 8'h0C);
    ds_chk(0, 16'h005F, 1, 8'h0C);
    ds_chk(0, 16'h0100, 0, 8'h00);
    ds_chk(1, 16'h0005, 0, 8'h00);
    ds_write(0, 16'h005F, 8'h00);
    $display("test flag access done");
    ds_write(0, 16'h001F, 8'hA5);
    rd_a_addr_i = 5'h1F;
    #1 check(rd_a_data_o, 16'h00A5);
    res_write(0, 5'h05, 16'h0037);
    rd_b_addr_i = 5'h05;
    #1 check(rd_b_data_o, 16'h0037);
    ds_chk(0, 16'h0005, 1, 8'h37);
    res_write(1, 5'h1A, 16'h12FF);
    rd_a_addr_i = 5'h1A;
    #1 check(rd_pair_data_o, 16'h12FF);
    ds_chk(0, 16'h001B, 1, 8'h12);
    $display("test register file done");
    tick();
    ptr_sel_i = 5'h1A;
    ptr_op_i  = cpu_state_pkg::PTR_INC;
    #1 check(ptr_addr_o, 16'h12FF);
    tick();
    ptr_op_i  = cpu_state_pkg::PTR_DEC;
    #1 check(rd_pair_data_o, 16'h1300);
    check(ptr_addr_o, 16'h12FF);
    tick();
    ptr_op_i   = cpu_state_pkg::PTR_NONE;
    ptr_disp_i = 6'h3F;
    #1 check(rd_pair_data_o, 16'h12FF);
    check(ptr_addr_o, 16'h133E);
    tick();
    ptr_disp_i = 6'h00;
    #1 check(rd_pair_data_o, 16'h12FF);
    $display("test pointers done");
    ops    = '{cpu_state_pkg::SP_PUSH1, cpu_state_pkg::SP_PUSH2,
               cpu_state_pkg::SP_POP2, cpu_state_pkg::SP_POP1};
    sa_exp = '{16'h10FF, 16'h10FE, 16'h10FD, 16'h10FF};
    sp_exp = '{16'h10FE, 16'h10FC, 16'h10FE, 16'h10FF};
    for (int i = 0; i < 4; i++) begin
      tick();
      sp_op_i = ops[i];
      #1 check(stack_addr_o, sa_exp[i]);
      tick();
      sp_op_i = cpu_state_pkg::SP_HOLD;
      #1 check(stack_pointer_o, sp_exp[i]);
    end
    ds_write(1, 16'h003D, 8'h40);
    check(stack_pointer_o, 16'h1040);
    $display("test stack done");
    ds_chk(0, 16'h005F, 1, 8'h00);
    tick();
    gie_op_i      = cpu_state_pkg::GIE_SET;
    irq_request_i = 1'b1;
    #1 check(irq_take_o, 16'h0000);
    tick();
    gie_op_i = cpu_state_pkg::GIE_CLEAR;
    #1 check(cpu_condition_flags_o, 16'h0080);
    check(irq_take_o, 16'h0000);
    tick();
    gie_op_i           = cpu_state_pkg::GIE_HOLD;
    irq_return_instr_i = 1'b1;
    #1 check(cpu_condition_flags_o, 16'h0000);
    tick();
    irq_return_instr_i = 1'b0;
    irq_accept_i       = 1'b1;
    #1 check(irq_take_o, 16'h0001);
    tick();
    irq_accept_i = 1'b0;
    #1 check(cpu_condition_flags_o, 16'h0000);
    check(irq_take_o, 16'h0000);
    irq_request_i = 1'b0;
    ds_write(0, 16'h005F, 8'h00);
    $display("test interrupt enable done");
    alu_op(8'h7F, 8'h01, 6'h3F);
    check(cpu_condition_flags_o, 16'h002C);
    alu_op(8'hFF, 8'h01, 6'h3F);
    check(cpu_condition_flags_o, 16'h0023);
    alu_op(8'h80, 8'h80, 6'h08);
    check(cpu_condition_flags_o, 16'h003B);
    $display("test alu flags done");
    tick();
    bit_reg_i         = 5'h05;
    bit_sel_i         = 3'h2;
    bit_store_instr_i = 1'b1;
    tick();
    bit_store_instr_i = 1'b0;
    bit_reg_i         = 5'h06;
    bit_sel_i         = 3'h7;
    bit_load_instr_i  = 1'b1;
    #1 check(cpu_condition_flags_o, 16'h007B);
    tick();
    bit_load_instr_i = 1'b0;
    ds_chk(0, 16'h0006, 1, 8'h80);
    $display("test bit copy done");
    report_and_stop();
  end
endmodule : cpu_state_tb

`default_nettype wire
